// ==== src/sdc_pkg.sv ====
// shared constants, types and helpers of the sdram command link
package sdc_pkg;
   // ************************************************
   // timing
   // ************************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int ROW_CYCLE_NS = 90;
   localparam int ROW_CYCLE_CYC = (ROW_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MODE_PROGRAM_RECOVERY = 2;
   localparam int MASK_TO_OUTPUT_DELAY = 2;
   localparam int REFRESH_BURST_COUNT = 4096;
   // ************************************************
   // address and mode fields
   // ************************************************
   localparam int ADDR_W = 12;
   localparam int ADDR_BANK_BIT = 11;
   localparam int ADDR_ALL_BIT = 10;
   localparam int MODE_BL_LSB = 0;
   localparam int MODE_ILV_BIT = 3;
   localparam int MODE_LAT_LSB = 4;
   localparam logic [1:0] MODE_BL_RST = 2'h0;
   localparam logic MODE_ILV_RST = 1'b0;
   localparam logic [1:0] MODE_LAT_RST = 2'h1;
   // ************************************************
   // pin codes {ras_n, cas_n, we_n} with cs_n low
   // ************************************************
   localparam logic [2:0] PIN_MODE = 3'h0;
   localparam logic [2:0] PIN_REFRESH = 3'h1;
   localparam logic [2:0] PIN_DEACT = 3'h2;
   localparam logic [2:0] PIN_ACTIVATE = 3'h3;
   localparam logic [2:0] PIN_WRITE = 3'h4;
   localparam logic [2:0] PIN_READ = 3'h5;
   localparam logic [2:0] PIN_STOP = 3'h6;
   localparam logic [2:0] PIN_NOP = 3'h7;
   // user commands of the controller end; dqm low is the data unmask
   typedef enum logic [3:0] {
      no_operation_cmd = 4'h0,
      deselect_cmd = 4'h1,
      bank_activate_cmd = 4'h2,
      read_cmd = 4'h3,
      read_autoprecharge_cmd = 4'h4,
      write_cmd = 4'h5,
      write_autoprecharge_cmd = 4'h6,
      deactivate_one_bank_cmd = 4'h7,
      deactivate_both_banks_cmd = 4'h8,
      stop_cmd = 4'h9,
      auto_refresh_cmd = 4'hA,
      mode_program_cmd = 4'hB,
      self_refresh_cmd = 4'hC,
      power_down_entry_cmd = 4'hD,
      clock_resume_cmd = 4'hE
   } sdc_cmd_t;
   // index of the last beat for a burst length code (1, 2, 4, 8)
   function automatic logic [2:0] sdc_burst_last(input logic [1:0] bl);
      sdc_burst_last = 3'((4'h1 << bl) - 4'h1);
   endfunction
endpackage

// ==== src/sdc_if.sv ====
// pin bundle between the memory controller and the sdram device
`timescale 1ns/10ps
`default_nettype none
interface sdc_if #(
   parameter int DW = 8
) ();
   import sdc_pkg::*;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic dqm;
   logic cke;
   logic [ADDR_W-1:0] addr;
   logic [DW-1:0] dq_ctl;
   logic [DW-1:0] dq_dev;
   logic [DW-1:0] dq;
   logic dq_ctl_oe;
   logic dq_dev_oe;
   // shared data wire; an undriven wire reads as zero
   assign dq = dq_dev_oe ? dq_dev : (dq_ctl_oe ? dq_ctl : '0);
   modport dev (input cs_n, ras_n, cas_n, we_n, addr, dqm, cke, dq, output dq_dev, dq_dev_oe);
   modport ctl (output cs_n, ras_n, cas_n, we_n, addr, dqm, cke, dq_ctl, dq_ctl_oe,
      input dq, dq_dev_oe);
endinterface
`default_nettype wire

// ==== src/sdc_burst_addr.sv ====
// column address of one beat inside a burst
`timescale 1ns/10ps
`default_nettype none
module sdc_burst_addr
   import sdc_pkg::*;
#(
   parameter int COL_W = 4
) (
   input wire logic [COL_W-1:0] i_start,
   input wire logic [2:0] i_idx,
   input wire logic [1:0] i_bl,
   input wire logic i_ilv,
   output logic [COL_W-1:0] o_col
);
   logic [2:0] mask;
   logic [2:0] low;
   always_comb begin
      mask = sdc_burst_last(i_bl);
      low = i_ilv ? (i_start[2:0] ^ i_idx) : 3'(i_start[2:0] + i_idx);
      o_col = (i_start & ~COL_W'(mask)) | COL_W'(low & mask);
   end
endmodule
`default_nettype wire

// ==== src/sdc_device.sv ====
// sdram device end: command decode, banks, bursts, masking, power states
// Functional notes
// - auto-deactivate closes bank after burst
// - activate opens, deactivate closes one/both banks
// - bursts 8/4/2/1, sequential or interleaved
// - controller interrupts bursts on even offsets
// - cke low mid-burst suspends, resumes later
// - cke low, banks idle: power-down
// - masked cycle: no data in or out
// - read mask two cycles late, write immediate
// - nop/deselect keeps state, bursts continue
// - stop ends burst, bank stays active
// - mode program sets type, latency, length
// - controller waits after mode program
// - refresh decode; only with banks idle
// - controller refreshes on a user refresh command and in the burst after self refresh, never on a timer
// - cke low plus refresh: self refresh
// - after self refresh wait, then refresh burst
// - first write word with command
// - first read word after read latency
// - deactivate mid-read: outputs off later
// - two banks allow gapless interleaving
`timescale 1ns/10ps
`default_nettype none
module sdc_device
   import sdc_pkg::*;
#(
   parameter int DW = 8,
   parameter int ROW_W = 4,
   parameter int COL_W = 4
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   sdc_if.dev bus,
   output logic [1:0] o_bank_active,
   output logic o_power_down,
   output logic o_self_refresh,
   output logic o_cmd_error
);
   // ************************************************
   // state
   // ************************************************
   typedef enum logic [4:0] {
      DS_IDLE = 5'h01,
      DS_READ = 5'h02,
      DS_WRITE = 5'h04,
      DS_PDOWN = 5'h08,
      DS_SREF = 5'h10
   } sdc_dev_st_t;
   typedef struct packed {
      sdc_dev_st_t st;
      logic [1:0] act;
      logic [1:0][ROW_W-1:0] row;
      logic [1:0] bl;
      logic ilv;
      logic [1:0] lat;
      logic bbank;
      logic [COL_W-1:0] bcol;
      logic [2:0] idx;
      logic bap;
      logic [2:0] pv;
      logic [2:0][DW-1:0] pd;
      logic [MASK_TO_OUTPUT_DELAY-1:0] mq;
      logic err;
   } sdc_dev_s_t;
   localparam sdc_dev_s_t DEV_RST = '{st: DS_IDLE, bl: MODE_BL_RST, ilv: MODE_ILV_RST,
      lat: MODE_LAT_RST, default: '0};
   localparam int MEM_AW = 1 + ROW_W + COL_W;
   sdc_dev_s_t r;
   sdc_dev_s_t n;
   logic [DW-1:0] mem [0:(1 << MEM_AW)-1];
   logic [2:0] cmd;
   logic bank;
   logic all;
   logic live;
   logic new_burst;
   logic [COL_W-1:0] b_start;
   logic [COL_W-1:0] b_col;
   logic [2:0] b_idx;
   logic b_bank;
   logic [MEM_AW-1:0] b_addr;
   logic [DW-1:0] rd_data;
   logic [1:0] lat_i;
   logic beat;
   logic beat_wr;
   logic wr_en;
   // ************************************************
   // pin decode and beat address
   // ************************************************
   // cs high deselects
   assign cmd = bus.cs_n ? PIN_NOP : {bus.ras_n, bus.cas_n, bus.we_n};
   assign bank = bus.addr[ADDR_BANK_BIT];
   assign all = bus.addr[ADDR_ALL_BIT];
   assign live = bus.cke && (r.st == DS_IDLE || r.st == DS_READ || r.st == DS_WRITE);
   // either bank may start a burst
   assign new_burst = live && (cmd == PIN_READ || cmd == PIN_WRITE) && r.act[bank];
   assign b_start = new_burst ? bus.addr[COL_W-1:0] : r.bcol;
   assign b_idx = new_burst ? 3'h0 : r.idx;
   assign b_bank = new_burst ? bank : r.bbank;
   assign b_addr = {b_bank, r.row[b_bank], b_col};
   assign rd_data = mem[b_addr];

   sdc_burst_addr #(
      .COL_W(COL_W)
   ) i_sdc_burst_addr (
      .i_start(b_start),
      .i_idx(b_idx),
      .i_bl(r.bl),
      .i_ilv(r.ilv),
      .o_col(b_col)
   );

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      n = r;
      n.err = 1'b0;
      beat = 1'b0;
      beat_wr = 1'b0;
      wr_en = 1'b0;
      if (r.st == DS_PDOWN || r.st == DS_SREF) begin
         // low power held while cke low
         if (bus.cke) begin
            n.st = DS_IDLE;
         end
      end else if (!bus.cke) begin
         if (r.st == DS_IDLE && r.act == 2'h0) begin
            n.st = (cmd == PIN_REFRESH) ? DS_SREF : DS_PDOWN;
            n.pv = '0;
         end
      end else begin
         n.pv = {r.pv[1:0], 1'b0};
         n.pd = {r.pd[1:0], rd_data};
         n.mq = {r.mq[MASK_TO_OUTPUT_DELAY-2:0], bus.dqm};
         beat = (r.st == DS_READ || r.st == DS_WRITE);
         beat_wr = (r.st == DS_WRITE);
         unique case (cmd)
            PIN_ACTIVATE: begin
               if (all) begin
                  n.act = 2'h3;
                  n.row[0] = bus.addr[ROW_W-1:0];
                  n.row[1] = bus.addr[ROW_W-1:0];
               end else begin
                  n.act[bank] = 1'b1;
                  n.row[bank] = bus.addr[ROW_W-1:0];
               end
            end
            PIN_READ, PIN_WRITE: begin
               if (new_burst) begin
                  beat = 1'b1;
                  beat_wr = (cmd == PIN_WRITE);
                  n.bbank = bank;
                  n.bcol = bus.addr[COL_W-1:0];
                  n.bap = all;
               end else begin
                  n.err = 1'b1;
               end
            end
            PIN_DEACT: begin
               if (all) begin
                  n.act = 2'h0;
               end else begin
                  n.act[bank] = 1'b0;
               end
               if (all || bank == r.bbank) begin
                  beat = 1'b0;
               end
            end
            PIN_STOP: begin
               beat = 1'b0;
            end
            PIN_REFRESH: begin
               n.err = (r.act != 2'h0);
            end
            PIN_MODE: begin
               if (r.act == 2'h0) begin
                  n.bl = bus.addr[MODE_BL_LSB +: 2];
                  n.ilv = bus.addr[MODE_ILV_BIT];
                  n.lat = bus.addr[MODE_LAT_LSB +: 2];
               end else begin
                  n.err = 1'b1;
               end
            end
            PIN_NOP: begin
            end
         endcase
         if (beat) begin
            if (beat_wr) begin
               wr_en = !bus.dqm;
            end else begin
               n.pv[0] = 1'b1;
            end
            n.idx = 3'(b_idx + 3'h1);
            n.st = beat_wr ? DS_WRITE : DS_READ;
            if (b_idx == sdc_burst_last(r.bl)) begin
               n.st = DS_IDLE;
               if (new_burst ? all : r.bap) begin
                  n.act[b_bank] = 1'b0;
               end
            end
         end else begin
            n.st = DS_IDLE;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         r <= DEV_RST;
      end else begin
         r <= n;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (wr_en) begin
         mem[b_addr] <= bus.dq;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   // tap at read latency
   assign lat_i = (r.lat == 2'h0) ? 2'h0 : 2'(r.lat - 2'h1);
   assign bus.dq_dev = r.pd[lat_i];
   assign bus.dq_dev_oe = r.pv[lat_i] && !r.mq[MASK_TO_OUTPUT_DELAY-1];
   assign o_bank_active = r.act;
   assign o_power_down = (r.st == DS_PDOWN);
   assign o_self_refresh = (r.st == DS_SREF);
   assign o_cmd_error = r.err;
endmodule
`default_nettype wire

// ==== src/sdc_ctrl.sv ====
// memory controller end: user commands to sdram pins with spacing checks
`timescale 1ns/10ps
`default_nettype none
module sdc_ctrl
   import sdc_pkg::*;
#(
   parameter int DW = 8,
   parameter int REFRESH_BURST = REFRESH_BURST_COUNT
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   sdc_if.ctl bus,
   input wire logic i_valid,
   input wire sdc_cmd_t i_cmd,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DW-1:0] i_wdata,
   input wire logic i_dqm,
   output logic o_ready,
   output logic [DW-1:0] o_rdata,
   output logic o_rvalid,
   output logic o_refreshing
);
   typedef enum logic [3:0] {
      CS_RUN = 4'h1,
      CS_PDOWN = 4'h2,
      CS_SREF = 4'h4,
      CS_REFB = 4'h8
   } sdc_ctl_st_t;
   typedef struct packed {
      sdc_ctl_st_t st;
      logic [1:0] act;
      logic [1:0] bl;
      logic [2:0] bleft;
      logic boff;
      logic [2:0] wleft;
      logic [3:0] wait_c;
      logic [12:0] refleft;
      logic cs_n;
      logic [2:0] cmd;
      logic [ADDR_W-1:0] addr;
      logic dqm;
      logic cke;
      logic [DW-1:0] dq;
      logic dqoe;
      logic [DW-1:0] rdata;
      logic rvalid;
   } sdc_ctl_s_t;
   localparam sdc_ctl_s_t CTL_RST = '{st: CS_RUN, bl: MODE_BL_RST, cs_n: 1'b1, cmd: PIN_NOP,
      cke: 1'b1, default: '0};
   sdc_ctl_s_t r;
   sdc_ctl_s_t n;
   logic col;
   logic brk;
   logic ref_req;
   logic ab;
   logic ready;
   always_comb begin
      n = r;
      ready = 1'b0;
      ab = i_addr[ADDR_BANK_BIT];
      col = i_cmd inside {read_cmd, read_autoprecharge_cmd, write_cmd, write_autoprecharge_cmd};
      brk = col || i_cmd inside {stop_cmd, deactivate_one_bank_cmd, deactivate_both_banks_cmd};
      ref_req = i_cmd inside {auto_refresh_cmd, self_refresh_cmd};
      n.cs_n = 1'b0;
      n.cmd = PIN_NOP;
      n.dqm = i_dqm;
      n.rvalid = bus.dq_dev_oe;
      n.rdata = bus.dq;
      n.bleft = (r.bleft == 3'h0) ? 3'h0 : 3'(r.bleft - 3'h1);
      n.boff = !r.boff;
      n.dqoe = (r.wleft != 3'h0);
      n.dq = i_wdata;
      n.wleft = (r.wleft == 3'h0) ? 3'h0 : 3'(r.wleft - 3'h1);
      n.wait_c = (r.wait_c == 4'h0) ? 4'h0 : 4'(r.wait_c - 4'h1);
      unique case (r.st)
         CS_RUN: begin
            if (!i_valid || r.wait_c != 4'h0) begin
            end else if (brk && r.bleft != 3'h0 && r.boff) begin
            end else if (ref_req && r.bleft != 3'h0) begin
            end else if (ref_req && r.act != 2'h0) begin
               n.cmd = PIN_DEACT;
               n.addr = i_addr;
               n.addr[ADDR_ALL_BIT] = 1'b1;
               n.act = 2'h0;
            end else begin
               ready = 1'b1;
               n.addr = i_addr;
               if (brk) begin
                  n.wleft = 3'h0;
                  n.dqoe = 1'b0;
                  n.bleft = 3'h0;
               end
               if (col) begin
                  n.bleft = sdc_burst_last(r.bl);
                  n.boff = 1'b1;
                  n.addr[ADDR_ALL_BIT] = i_cmd inside {read_autoprecharge_cmd,
                     write_autoprecharge_cmd};
                  if (n.addr[ADDR_ALL_BIT]) begin
                     n.act[ab] = 1'b0;
                  end
               end
               unique case (i_cmd)
                  bank_activate_cmd: begin
                     n.cmd = PIN_ACTIVATE;
                     if (i_addr[ADDR_ALL_BIT]) begin
                        n.act = 2'h3;
                     end else begin
                        n.act[ab] = 1'b1;
                     end
                  end
                  read_cmd, read_autoprecharge_cmd: n.cmd = PIN_READ;
                  write_cmd, write_autoprecharge_cmd: begin
                     n.cmd = PIN_WRITE;
                     n.dqoe = 1'b1;
                     n.wleft = sdc_burst_last(r.bl);
                  end
                  deactivate_one_bank_cmd: begin
                     n.cmd = PIN_DEACT;
                     n.addr[ADDR_ALL_BIT] = 1'b0;
                     n.act[ab] = 1'b0;
                  end
                  deactivate_both_banks_cmd: begin
                     n.cmd = PIN_DEACT;
                     n.addr[ADDR_ALL_BIT] = 1'b1;
                     n.act = 2'h0;
                  end
                  stop_cmd: n.cmd = PIN_STOP;
                  auto_refresh_cmd: n.cmd = PIN_REFRESH;
                  mode_program_cmd: begin
                     n.cmd = PIN_MODE;
                     n.bl = i_addr[MODE_BL_LSB +: 2];
                     n.wait_c = 4'(MODE_PROGRAM_RECOVERY);
                  end
                  self_refresh_cmd: begin
                     n.cmd = PIN_REFRESH;
                     n.cke = 1'b0;
                     n.st = CS_SREF;
                  end
                  power_down_entry_cmd: begin
                     n.cke = 1'b0;
                     n.st = CS_PDOWN;
                  end
                  deselect_cmd: n.cs_n = 1'b1;
                  default: begin
                  end
               endcase
            end
         end
         CS_PDOWN, CS_SREF: begin
            if (i_valid && i_cmd == clock_resume_cmd) begin
               ready = 1'b1;
               n.cke = 1'b1;
               n.st = (r.st == CS_SREF) ? CS_REFB : CS_RUN;
               // row cycle wait, then refresh burst if leaving self refresh
               n.wait_c = 4'(ROW_CYCLE_CYC);
               n.refleft = 13'(REFRESH_BURST);
            end
         end
         CS_REFB: begin
            // full refresh burst after self refresh
            if (r.wait_c == 4'h0) begin
               if (r.refleft == 13'h0) begin
                  n.st = CS_RUN;
               end else begin
                  n.cmd = PIN_REFRESH;
                  n.refleft = 13'(r.refleft - 13'h1);
                  n.wait_c = 4'(ROW_CYCLE_CYC);
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         r <= CTL_RST;
      end else begin
         r <= n;
      end
   end

   assign o_ready = ready;
   assign bus.cs_n = r.cs_n;
   assign bus.ras_n = r.cmd[2];
   assign bus.cas_n = r.cmd[1];
   assign bus.we_n = r.cmd[0];
   assign bus.addr = r.addr;
   assign bus.dqm = r.dqm;
   assign bus.cke = r.cke;
   assign bus.dq_ctl = r.dq;
   assign bus.dq_ctl_oe = r.dqoe;
   assign o_rdata = r.rdata;
   assign o_rvalid = r.rvalid;
   assign o_refreshing = (r.st == CS_REFB);
endmodule
`default_nettype wire

// ==== tb/sdc_monitor.sv ====
// assertion checker on the sdram command pins
`timescale 1ns/10ps
`default_nettype none
module sdc_monitor
   import sdc_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic dqm,
   input wire logic cke,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic dq_ctl_oe,
   input wire logic dq_dev_oe
);
   // ************************************************
   // pin decode and mode tracking
   // ************************************************
   logic [2:0] code;
   logic on, rd, wr, md, dea, idle;
   logic [1:0] bl_r;
   logic [1:0] lat_r;
   assign code = {ras_n, cas_n, we_n};
   assign on = !cs_n && cke;
   assign rd = on && (code == PIN_READ);
   assign wr = on && (code == PIN_WRITE);
   assign md = on && (code == PIN_MODE);
   assign dea = on && (code == PIN_DEACT);
   assign idle = !on || (code == PIN_NOP);
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         bl_r <= MODE_BL_RST;
         lat_r <= MODE_LAT_RST;
      end else if (md) begin
         bl_r <= addr[MODE_BL_LSB +: 2];
         lat_r <= addr[MODE_LAT_LSB +: 2];
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   chk_read_mask_off: assert property (dq_dev_oe |-> !$past(dqm, 2))
      else $error("read data driven two cycles after mask");
   chk_no_contention: assert property (!(dq_dev_oe && dq_ctl_oe))
      else $error("both ends drive the data wire");
   chk_write_word_now: assert property (wr |-> dq_ctl_oe)
      else $error("first write word not with write command");
   chk_mode_recovery: assert property (md |=> idle ##1 idle)
      else $error("command too soon after mode program");
   chk_read_lat_one: assert property (rd && lat_r == 2'h1 |=> dq_dev_oe || $past(dqm, 2))
      else $error("read word late for latency one");
   chk_read_lat_three: assert property (rd && lat_r == 2'h3 |-> ##3 (dq_dev_oe || $past(dqm, 2)))
      else $error("read word late for latency three");
   chk_burst_four_len: assert property (rd && lat_r == 2'h1 && bl_r == 2'h2 ##1 (idle && !dqm)[*4]
      |-> dq_dev_oe ##1 !dq_dev_oe)
      else $error("read burst of four has wrong length");
   chk_deact_highz: assert property (dea && lat_r == 2'h1 |=> !dq_dev_oe)
      else $error("outputs still on after deactivate");
endmodule
`default_nettype wire

// ==== tb/tb_sdram_command_protocol.sv ====
// self-checking bench joining the controller and device ends
`timescale 1ns/10ps
`default_nettype none
module tb_sdram_command_protocol;
   import sdc_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic valid = 1'b0;
   sdc_cmd_t cmd = no_operation_cmd;
   logic [ADDR_W-1:0] addr = '0;
   logic [7:0] wdata = '0;
   logic dqm = 1'b0;
   logic ready, rvalid, refreshing, pdown, sref, cerr;
   logic [7:0] rdata;
   logic [1:0] banks;
   logic [7:0] mem [0:31];
   logic [7:0] exp_q [$];
   int n_mismatch = 0;
   int samples_checked = 0;
   int cycles = 0;
   sdc_if i_sdc_if ();
   sdc_ctrl #(.REFRESH_BURST(4)) i_sdc_ctrl (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .bus(i_sdc_if.ctl), .i_valid(valid), .i_cmd(cmd), .i_addr(addr), .i_wdata(wdata),
      .i_dqm(dqm), .o_ready(ready), .o_rdata(rdata), .o_rvalid(rvalid),
      .o_refreshing(refreshing));
   sdc_device i_sdc_device (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .bus(i_sdc_if.dev),
      .o_bank_active(banks), .o_power_down(pdown), .o_self_refresh(sref), .o_cmd_error(cerr));
   sdc_monitor i_sdc_monitor (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .cs_n(i_sdc_if.cs_n),
      .ras_n(i_sdc_if.ras_n), .cas_n(i_sdc_if.cas_n), .we_n(i_sdc_if.we_n),
      .dqm(i_sdc_if.dqm), .cke(i_sdc_if.cke), .addr(i_sdc_if.addr),
      .dq_ctl_oe(i_sdc_if.dq_ctl_oe), .dq_dev_oe(i_sdc_if.dq_dev_oe));
   // ************************************************
   // clock, checks and drivers
   // ************************************************
   initial begin
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   task automatic report_and_stop();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t data got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_flag(input logic [1:0] got, input logic [1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t status got %h expected %h", $time, got, exp);
      end
   endtask
   always @(posedge i_ref_clk) begin
      #1;
      if (rvalid === 1'b1) begin
         cmp_data(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
      end
   end
   task automatic step();
      @(posedge i_ref_clk);
      #5;
   endtask
   task automatic idle(input int n);
      valid = 1'b0;
      repeat (n) step();
   endtask
   task automatic issue(input sdc_cmd_t c, input logic [ADDR_W-1:0] a);
      valid = 1'b1;
      cmd = c;
      addr = a;
      @(negedge i_ref_clk);
      while (ready !== 1'b1) @(negedge i_ref_clk);
      step();
   endtask
   task automatic wait_flag(ref logic s, input logic v);
      int k;
      valid = 1'b0;
      for (k = 0; k < 40 && s !== v; k++) step();
      cmp_flag({1'b0, s}, {1'b0, v});
   endtask
   task automatic wr(input logic b, input logic [3:0] c, input int mb,
      input sdc_cmd_t wc = write_cmd);
      int k;
      logic [7:0] d;
      for (k = 0; k < 4; k++) begin
         d = 8'($urandom);
         wdata = d;
         dqm = (k == mb);
         if (k == 0) issue(wc, {b, 7'h00, c});
         else idle(1);
         if (k != mb) mem[{b, c[3:2], c[1:0] + 2'(k)}] = d;
      end
      dqm = 1'b0;
   endtask
   task automatic rd(input sdc_cmd_t c, input logic b, input logic [3:0] s, input logic ilv,
      input int n, input int mb);
      int k;
      logic [3:0] col;
      for (k = 0; k < n; k++) begin
         col = ilv ? s ^ 4'(k) : {s[3:2], s[1:0] + 2'(k)};
         if (k != mb) exp_q.push_back(mem[{b, col}]);
      end
      issue(c, {b, 7'h00, s});
      if (mb >= 0) begin
         valid = 1'b0;
         dqm = 1'b1;
         step();
         dqm = 1'b0;
      end
   endtask
   initial begin
      void'($urandom(52));
      repeat (4) @(posedge i_ref_clk);
      #5;
      i_rst = 1'b0;
      issue(mode_program_cmd, 12'h032);
      idle(3);
      issue(bank_activate_cmd, 12'h401);
      idle(1);
      wr(1'b0, 4'h4, -1);
      wr(1'b0, 4'h4, 1);
      rd(read_cmd, 1'b0, 4'h6, 1'b0, 4, -1);
      idle(8);
      issue(deactivate_both_banks_cmd, 12'h400);
      idle(2);
      issue(mode_program_cmd, 12'h01A);
      idle(3);
      issue(bank_activate_cmd, 12'h401);
      idle(1);
      rd(read_autoprecharge_cmd, 1'b0, 4'h5, 1'b1, 4, 2);
      idle(8);
      cmp_flag(banks, 2'h2);
      issue(bank_activate_cmd, 12'h001);
      idle(2);
      cmp_flag(banks, 2'h3);
      wr(1'b0, 4'h0, -1);
      wr(1'b1, 4'h0, -1);
      rd(read_cmd, 1'b0, 4'h0, 1'b1, 4, -1);
      idle(3);
      rd(read_cmd, 1'b1, 4'h0, 1'b1, 4, -1);
      idle(8);
      rd(read_cmd, 1'b0, 4'h0, 1'b1, 2, -1);
      rd(read_cmd, 1'b1, 4'h0, 1'b1, 2, -1);
      issue(deactivate_one_bank_cmd, 12'h800);
      idle(6);
      cmp_flag(banks, 2'h1);
      issue(auto_refresh_cmd, 12'h000);
      idle(8);
      cmp_flag(banks, 2'h0);
      issue(power_down_entry_cmd, 12'h000);
      wait_flag(pdown, 1'b1);
      issue(clock_resume_cmd, 12'h000);
      wait_flag(pdown, 1'b0);
      issue(self_refresh_cmd, 12'h000);
      wait_flag(sref, 1'b1);
      idle(20);
      cmp_flag({pdown, sref}, 2'h1);
      issue(clock_resume_cmd, 12'h000);
      wait_flag(refreshing, 1'b1);
      wait_flag(refreshing, 1'b0);
      issue(bank_activate_cmd, 12'h001);
      idle(1);
      rd(read_cmd, 1'b0, 4'h0, 1'b1, 4, -1);
      idle(10);
      rd(read_cmd, 1'b0, 4'h4, 1'b1, 2, -1);
      issue(deselect_cmd, 12'h000);
      issue(stop_cmd, 12'h000);
      idle(2);
      cmp_flag(banks, 2'h1);
      wr(1'b0, 4'h8, -1, write_autoprecharge_cmd);
      idle(2);
      cmp_flag(banks, 2'h0);
      issue(mode_program_cmd, 12'h023);
      idle(3);
      issue(read_cmd, 12'h000);
      idle(1);
      cmp_flag({1'b0, cerr}, 2'h1);
      issue(bank_activate_cmd, 12'h001);
      idle(1);
      rd(read_cmd, 1'b0, 4'h0, 1'b1, 8, -1);
      idle(12);
      cmp_flag(2'(exp_q.size()), 2'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
